//--- io_channel_instruction_control.sv
// Execution of I/O channel instructions with an APB status and interrupt register file
`timescale 1ns/1ps
module io_channel_instruction_control
    import io_instr_pkg::*;
#(
    parameter int unsigned NCHAN = 32
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [APB_AW-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Interrupt
    output logic                    irq,
    // Instruction sequencer
    input  wire logic               instr_valid,
    input  wire logic [OP_W-1:0]    instr_opcode,
    input  wire logic [DESIG_W-1:0] instr_desig,
    input  wire logic [ADDR_W-1:0]  instr_eaddr,
    input  wire logic [WORD_W-1:0]  instr_operand,
    output logic                    instr_busy,
    output logic                    instr_done,
    output logic                    jump_taken,
    output logic      [TGT_W-1:0]   jump_target,
    // I/O function priority
    output logic                    io_req,
    input  wire logic               io_grant,
    // Main storage write port
    output logic                    mem_wr,
    output logic      [ADDR_W-1:0]  mem_addr,
    output logic      [WORD_W-1:0]  mem_wdata,
    input  wire logic               mem_wr_ack,
    // Channel pins
    output logic      [CHAN_W-1:0]  chan_sel,
    output logic                    func_strobe,
    output logic      [WORD_W-1:0]  func_word,
    input  wire logic               ext_int_pin,
    input  wire logic [WORD_W-1:0]  status_pins,
    input  wire logic [CHAN_W-1:0]  int_chan,
    output logic                    data_ack,
    output logic      [CHAN_W-1:0]  ack_chan,
    // Buffer control
    input  wire logic [NCHAN-1:0]   in_active,
    input  wire logic [NCHAN-1:0]   out_active,
    input  wire logic [NCHAN-1:0]   in_xfer_busy,
    input  wire logic [NCHAN-1:0]   mon_req,
    input  wire logic               in_activate,
    output logic      [NCHAN-1:0]   in_block,
    output logic                    in_term,
    output logic                    mon_irq,
    output logic                    ef_buffer_start,
    output logic                    alarm
);
    typedef struct packed {
        state_t              state;
        logic                is_store;
        logic [CHAN_W-1:0]   chan;
        logic [WORD_W-1:0]   word;
        logic [ADDR_W-1:0]   addr;
        logic                busy;
        logic                done;
        logic                jump_taken;
        logic [TGT_W-1:0]    target;
        logic                io_req;
        logic                mem_wr;
        logic [CHAN_W-1:0]   chan_sel;
        logic                func_strobe;
        logic                ef_start;
        logic                data_ack;
        logic [CHAN_W-1:0]   ack_chan;
        logic                ext_q;
        logic [NCHAN-1:0]    in_block;
        logic                in_term;
        logic                mon_irq;
        logic                alarm;
        logic [EV_W-1:0]     ev;
        logic [EV_W-1:0]     en;
        logic                irq;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } regs_t;

    regs_t q;
    regs_t d;

    logic              ext_int_s;
    logic [WORD_W-1:0] status_s;

    if (NCHAN < 1 || NCHAN > (1 << CHAN_W)) begin : g_bad_nchan
        $error("io_channel_instruction_control: NCHAN must lie in 1..32");
    end

    // Interrupt line and status lines come from the peripheral
    sync_2ff #(.WIDTH(1 + WORD_W)) u_pin_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({ext_int_pin, status_pins}),
        .q       ({ext_int_s, status_s})
    );

    // Jump target by operand mode
    function automatic logic [TGT_W-1:0] pick_target(
        input logic [K_W-1:0]    k,
        input logic [ADDR_W-1:0] ea,
        input logic [WORD_W-1:0] op
    );
        logic [TGT_W-1:0] t;
        case (k)
            K_ADDR:  t = ea[TGT_W-1:0];
            K_UPPER: t = op[UPPER_LSB +: TGT_W];
            default: t = op[TGT_W-1:0];
        endcase
        return t;
    endfunction

    logic            accept;
    logic [J_W-1:0]  j_f;
    logic [K_W-1:0]  k_f;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [NCHAN-1:0] blk_set;
    logic [NCHAN-1:0] blk_clr;
    logic            apb_acc;

    assign accept  = instr_valid && !q.busy;
    assign j_f     = instr_desig[J_LSB +: J_W];
    assign k_f     = instr_desig[K_W-1:0];
    assign apb_acc = psel && penable && !q.pready;

    always_comb begin
        d             = q;
        ev_set        = '0;
        ev_clr        = '0;
        blk_set       = '0;
        blk_clr       = '0;
        d.done        = 1'b0;
        d.jump_taken  = 1'b0;
        d.func_strobe = 1'b0;
        d.ef_start    = 1'b0;
        d.data_ack    = 1'b0;
        d.in_term     = 1'b0;
        d.pready      = 1'b0;
        d.pslverr     = 1'b0;
        d.ext_q       = ext_int_s;
        if (ext_int_s && !q.ext_q) begin
            ev_set[EV_EXT_INT] = 1'b1;
        end

        case (q.state)
            S_IDLE: begin
                if (accept) begin
                    d.addr     = instr_eaddr;
                    d.chan     = q.chan_sel;
                    d.is_store = 1'b0;
                    if (instr_opcode == OP_SEND_FUNC) begin
                        if (k_f == K_FULL) begin
                            // No output data request is awaited; only priority gates it
                            d.word   = instr_operand;
                            d.io_req = 1'b1;
                            d.state  = S_ARB;
                        end else begin
                            d.done = 1'b1;
                            if (k_f == K_ADDR) begin
                                // A disable request overrides a simultaneous enable
                                if (instr_eaddr[ALARM_OFF_BIT]) begin
                                    d.alarm = 1'b0;
                                end else if (instr_eaddr[ALARM_ON_BIT]) begin
                                    d.alarm = 1'b1;
                                end
                            end
                        end
                        if (j_f != '0) begin
                            ev_set[EV_BAD_DESIG] = 1'b1;
                        end
                    end else if (instr_opcode == OP_STORE_STATUS) begin
                        if (k_f == K_FULL) begin
                            d.is_store = 1'b1;
                            d.chan     = int_chan;
                            d.io_req   = 1'b1;
                            d.state    = S_ARB;
                        end else begin
                            d.done = 1'b1;
                        end
                    end else if (instr_opcode == OP_JUMP_IN) begin
                        d.done       = 1'b1;
                        d.jump_taken = in_active[q.chan_sel];
                        d.target     = pick_target(k_f, instr_eaddr, instr_operand);
                    end else if (instr_opcode == OP_JUMP_OUT) begin
                        d.done       = 1'b1;
                        d.jump_taken = out_active[q.chan_sel];
                        d.target     = pick_target(k_f, instr_eaddr, instr_operand);
                    end else if (instr_opcode == OP_TERM_IN) begin
                        if (instr_desig == '0) begin
                            d.state = S_TERM;
                        end else begin
                            d.done               = 1'b1;
                            ev_set[EV_BAD_DESIG] = 1'b1;
                        end
                    end else if (instr_opcode == OP_OUTBUF_NOMON) begin
                        // Odd condition marks a function buffer; its words carry the strobe
                        d.done     = 1'b1;
                        d.ef_start = j_f[0];
                    end else if (instr_opcode == OP_EXTENDED
                                 && instr_desig == SUB_CHAN_SELECT) begin
                        d.done     = 1'b1;
                        d.chan_sel = instr_operand[CHAN_W-1:0];
                    end else begin
                        d.done = 1'b1;
                    end
                end
            end
            S_ARB: begin
                if (io_grant) begin
                    d.io_req = 1'b0;
                    if (q.is_store) begin
                        d.word   = status_s;
                        d.mem_wr = 1'b1;
                        d.state  = S_MEM;
                    end else begin
                        d.func_strobe        = 1'b1;
                        d.done               = 1'b1;
                        ev_set[EV_FUNC_SENT] = 1'b1;
                        d.state              = S_IDLE;
                    end
                end
            end
            S_MEM: begin
                // The device holds the status word until this acknowledge
                if (mem_wr_ack) begin
                    d.mem_wr             = 1'b0;
                    d.data_ack           = 1'b1;
                    d.ack_chan           = q.chan;
                    d.done               = 1'b1;
                    ev_set[EV_STATUS_ST] = 1'b1;
                    d.state              = S_IDLE;
                end
            end
            S_TERM: begin
                // A word already moving on the channel is allowed to finish first
                if (!in_xfer_busy[q.chan]) begin
                    blk_set[q.chan]      = 1'b1;
                    d.in_term            = 1'b1;
                    d.done               = 1'b1;
                    ev_set[EV_TERM_DONE] = 1'b1;
                    d.state              = S_IDLE;
                end
            end
            default: begin
                d.state = S_IDLE;
            end
        endcase

        // APB slave: one wait state, registered answer
        if (apb_acc) begin
            d.pready = 1'b1;
            d.prdata = '0;
            if (paddr == OFF_IRQ_STATUS) begin
                d.prdata[EV_W-1:0] = q.ev;
                d.pslverr          = pwrite;
            end else if (paddr == OFF_IRQ_CLEAR) begin
                if (pwrite) begin
                    ev_clr = pwdata[EV_W-1:0];
                end
            end else if (paddr == OFF_IRQ_ENABLE) begin
                if (pwrite) begin
                    d.en = pwdata[EV_W-1:0];
                end else begin
                    d.prdata[EV_W-1:0] = q.en;
                end
            end else if (paddr == OFF_INFO) begin
                d.prdata[CHAN_W-1:0]    = q.chan_sel;
                d.prdata[INFO_ALARM_BIT] = q.alarm;
                d.prdata[INFO_BUSY_BIT]  = q.busy;
                d.pslverr                = pwrite;
            end else if (paddr == OFF_IN_BLOCK) begin
                if (pwrite) begin
                    blk_clr = pwdata[NCHAN-1:0];
                end else begin
                    d.prdata[NCHAN-1:0] = q.in_block;
                end
            end else begin
                d.pslverr = 1'b1;
            end
        end

        if (in_activate) begin
            blk_clr[q.chan_sel] = 1'b1;
        end
        // New events and new blocks win over a clear in the same cycle
        d.ev       = (q.ev & ~ev_clr) | ev_set;
        d.in_block = (q.in_block & ~blk_clr) | blk_set;
        // A blocked channel, or the one being cut off now, cannot raise monitor
        d.mon_irq  = |(mon_req & ~q.in_block & ~blk_set);
        d.irq      = |(d.ev & d.en);
        d.busy     = (d.state != S_IDLE);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q          <= '0;
            q.chan_sel <= CHAN_SEL_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata          = q.prdata;
    assign pready          = q.pready;
    assign pslverr         = q.pslverr;
    assign irq             = q.irq;
    assign instr_busy      = q.busy;
    assign instr_done      = q.done;
    assign jump_taken      = q.jump_taken;
    assign jump_target     = q.target;
    assign io_req          = q.io_req;
    assign mem_wr          = q.mem_wr;
    assign mem_addr        = q.addr;
    assign mem_wdata       = q.word;
    assign chan_sel        = q.chan_sel;
    assign func_strobe     = q.func_strobe;
    assign func_word       = q.word;
    assign data_ack        = q.data_ack;
    assign ack_chan        = q.ack_chan;
    assign in_block        = q.in_block;
    assign in_term         = q.in_term;
    assign mon_irq         = q.mon_irq;
    assign ef_buffer_start = q.ef_start;
    assign alarm           = q.alarm;

    // Checks
    sequence grant_seen;
        io_req && io_grant;
    endsequence

    sequence store_written;
        mem_wr && mem_wr_ack;
    endsequence

    a_send_after_grant: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(func_strobe) |-> $past(io_req && io_grant))
        else $error("function strobe without priority grant");

    a_send_word_out: assert property (@(posedge clk) disable iff (!reset_n)
        grant_seen and !mem_wr and q.state == S_ARB and !q.is_store
        |=> func_strobe && instr_done && $stable(func_word))
        else $error("function word not sent one cycle after grant");

    a_send_mode_noop: assert property (@(posedge clk) disable iff (!reset_n)
        accept && instr_opcode == OP_SEND_FUNC && k_f != K_FULL
        |=> !io_req && instr_done ##1 !func_strobe)
        else $error("send function acted with operand mode other than 3");

    a_alarm_on_off: assert property (@(posedge clk) disable iff (!reset_n)
        accept && instr_opcode == OP_SEND_FUNC && k_f == K_ADDR
        |=> alarm == ($past(instr_eaddr[ALARM_OFF_BIT]) ? 1'b0 :
                      $past(instr_eaddr[ALARM_ON_BIT]) ? 1'b1 : $past(alarm)))
        else $error("console alarm not steered by address bits");

    a_ack_after_write: assert property (@(posedge clk) disable iff (!reset_n)
        store_written |=> data_ack && !mem_wr ##1 !data_ack)
        else $error("input data acknowledge not one cycle after store");

    a_store_mode_noop: assert property (@(posedge clk) disable iff (!reset_n)
        accept && instr_opcode == OP_STORE_STATUS && k_f != K_FULL
        |=> instr_done && !io_req && !mem_wr)
        else $error("store status acted with operand mode other than 3");

    a_jump_in_target: assert property (@(posedge clk) disable iff (!reset_n)
        accept && instr_opcode == OP_JUMP_IN
        |=> jump_taken == $past(in_active[chan_sel])
            && jump_target == $past(pick_target(k_f, instr_eaddr, instr_operand)))
        else $error("input buffer jump wrong");

    a_jump_out_cond: assert property (@(posedge clk) disable iff (!reset_n)
        accept && instr_opcode == OP_JUMP_OUT |=> jump_taken == $past(out_active[chan_sel]))
        else $error("output buffer jump wrong");

    a_term_waits_xfer: assert property (@(posedge clk) disable iff (!reset_n)
        q.state == S_TERM && in_xfer_busy[q.chan] |=> !in_term && instr_busy)
        else $error("terminate did not wait for the word in progress");

    a_term_no_monitor: assert property (@(posedge clk) disable iff (!reset_n)
        in_term |-> !mon_irq || $past(|(mon_req & ~in_block & ~(NCHAN'(1) << q.chan))))
        else $error("monitor interrupt from terminated channel");

    a_term_desig_zero: assert property (@(posedge clk) disable iff (!reset_n)
        accept && instr_opcode == OP_TERM_IN && instr_desig != '0
        |=> instr_done && !instr_busy ##1 !in_term)
        else $error("terminate with nonzero designators acted");

    a_chan_sel_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !(accept && instr_opcode == OP_EXTENDED && instr_desig == SUB_CHAN_SELECT)
        |=> $stable(chan_sel))
        else $error("channel select changed without reload");
endmodule

//--- io_instr_pkg.sv
// Constants, encodings and register map for the I/O channel instruction control block
package io_instr_pkg;

    // Word and field widths
    localparam int unsigned WORD_W   = 30;
    localparam int unsigned ADDR_W   = 17;
    localparam int unsigned TGT_W    = 15;
    localparam int unsigned CHAN_W   = 5;
    localparam int unsigned OP_W     = 6;
    localparam int unsigned DESIG_W  = 6;

    // Designator field: condition designator in the upper four bits, operand mode in the low two
    localparam int unsigned J_LSB    = 2;
    localparam int unsigned J_W      = 4;
    localparam int unsigned K_W      = 2;

    // Operand-mode designator values
    localparam logic [1:0] K_ADDR    = 2'h0;
    localparam logic [1:0] K_LOWER   = 2'h1;
    localparam logic [1:0] K_UPPER   = 2'h2;
    localparam logic [1:0] K_FULL    = 2'h3;

    // Primary opcodes (octal 13, 17, 62, 63, 66, 74, 77) and the 77-group sub-code 73
    localparam logic [5:0] OP_SEND_FUNC    = 6'h0b;
    localparam logic [5:0] OP_STORE_STATUS = 6'h0f;
    localparam logic [5:0] OP_JUMP_IN      = 6'h32;
    localparam logic [5:0] OP_JUMP_OUT     = 6'h33;
    localparam logic [5:0] OP_TERM_IN      = 6'h36;
    localparam logic [5:0] OP_OUTBUF_NOMON = 6'h3c;
    localparam logic [5:0] OP_EXTENDED     = 6'h3f;
    localparam logic [5:0] SUB_CHAN_SELECT = 6'h3b;

    // Effective-address bits that steer the console alarm
    localparam int unsigned ALARM_ON_BIT  = 2;
    localparam int unsigned ALARM_OFF_BIT = 3;

    // Upper half of an operand word
    localparam int unsigned UPPER_LSB = 15;

    // Reset values
    localparam logic [4:0] CHAN_SEL_RST = 5'h00;

    // APB register byte offsets
    localparam int unsigned APB_AW        = 12;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h000;
    localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h004;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h008;
    localparam logic [11:0] OFF_INFO       = 12'h00c;
    localparam logic [11:0] OFF_IN_BLOCK   = 12'h010;

    // Event bits of the status, clear and enable registers
    localparam int unsigned EV_W          = 5;
    localparam int unsigned EV_FUNC_SENT  = 0;
    localparam int unsigned EV_STATUS_ST  = 1;
    localparam int unsigned EV_TERM_DONE  = 2;
    localparam int unsigned EV_EXT_INT    = 3;
    localparam int unsigned EV_BAD_DESIG  = 4;

    // Fields of the information register
    localparam int unsigned INFO_ALARM_BIT = 8;
    localparam int unsigned INFO_BUSY_BIT  = 9;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ARB,
        S_MEM,
        S_TERM
    } state_t;

endpackage

//--- io_periph_model.sv
// Peripheral, priority arbiter and storage model facing the I/O block
`timescale 1ns/1ps
module io_periph_model #(
    parameter int unsigned DLY = 3
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Requests from the block
    input  wire logic        io_req,
    input  wire logic        mem_wr,
    input  wire logic        data_ack,
    // Interrupt command from the bench
    input  wire logic        raise,
    input  wire logic [29:0] word,
    // Answers
    output logic             io_grant,
    output logic             mem_wr_ack,
    output logic             ext_int_pin,
    output logic      [29:0] status_pins
);
    int unsigned wait_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {io_grant, mem_wr_ack, ext_int_pin, status_pins} <= '0;
            wait_q <= 0;
        end else begin
            // Slow grant so a block that skips arbitration shows it
            wait_q     <= (io_req && !io_grant) ? wait_q + 1 : 0;
            io_grant   <= io_req && !io_grant && wait_q >= DLY;
            mem_wr_ack <= mem_wr && !mem_wr_ack;
            if (raise) begin
                ext_int_pin <= 1'h1;
                status_pins <= word;
            end else if (data_ack) begin
                // Released lines flip so stale status is never mistaken for valid
                ext_int_pin <= 1'h0;
                status_pins <= ~status_pins;
            end
        end
    end
endmodule

//--- sync_2ff.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sync_2ff #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Asynchronous input and its synchronised copy
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    if (WIDTH < 1) begin : g_bad_width
        $error("sync_2ff: WIDTH must be at least 1");
    end

    // The first stage feeds only the second
    always_comb begin
        s_d        = s_q;
        s_d.meta   = d;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.stable;
endmodule

//--- test_io_channel_instruction_control.sv
// Self-checking bench for the I/O channel instruction block
`timescale 1ns/1ps
module test_io_channel_instruction_control;
    import io_instr_pkg::*;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, er, instr_valid;
    logic        instr_busy, instr_done, jump_taken, io_req, io_grant, mem_wr, mem_wr_ack;
    logic        func_strobe, ext_int_pin, data_ack, in_activate, in_term, mon_irq, raise;
    logic        ef_buffer_start, alarm, s_fs, s_j, s_mw, s_ack, s_term, s_ef;
    logic [4:0]  chan_sel, int_chan, ack_chan, c_ac;
    logic [5:0]  instr_opcode, instr_desig;
    logic [11:0] paddr;
    logic [14:0] jump_target, c_jt;
    logic [16:0] instr_eaddr, mem_addr, c_ma;
    logic [29:0] instr_operand, mem_wdata, func_word, status_pins, word, c_fw, c_md;
    logic [31:0] pwdata, prdata, rd, in_active, out_active, in_xfer_busy, mon_req, in_block;
    int          miscompares, n_compared, ncyc, cyc;
    io_channel_instruction_control DUT (.*);
    io_periph_model peer (.*);
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (func_strobe) {s_fs, c_fw} <= {1'h1, func_word};
        if (jump_taken) {s_j, c_jt} <= {1'h1, jump_target};
        if (mem_wr) {s_mw, c_ma, c_md} <= {1'h1, mem_addr, mem_wdata};
        if (data_ack) {s_ack, c_ac} <= {1'h1, ack_chan};
        if (in_term) s_term <= 1'h1;
        if (ef_buffer_start) s_ef <= 1'h1;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic ex(input logic [5:0] op, d, input logic [16:0] ea, input logic [29:0] w);
        {s_fs, s_j, s_mw, s_ack, s_term, s_ef} = '0;
        ncyc = 0;
        @(posedge clk);
        {instr_opcode, instr_desig, instr_eaddr, instr_operand} <= {op, d, ea, w};
        instr_valid <= 1'h1;
        @(posedge clk);
        instr_valid <= 1'h0;
        do begin
            @(posedge clk);
            ncyc++;
        end while (instr_done !== 1'h1);
        @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic t_send();
        ex(OP_EXTENDED, SUB_CHAN_SELECT, 17'h0, 30'h3fffffec);
        chk("chan_sel", chan_sel, 32'h0c);
        apb(1'h0, 12'h100, 32'h0);
        chk("unmapped", er, 1);
        apb(1'h1, OFF_IRQ_ENABLE, 32'h1);
        ex(OP_SEND_FUNC, 6'h03, 17'h01010, 30'h00300007);
        chk("strobe", s_fs, 1);
        chk("func_word", c_fw, 32'h00300007);
        chk("grant_wait", ncyc > 3, 1);
        chk("irq_set", irq, 1);
        apb(1'h1, OFF_IRQ_CLEAR, 32'h1);
        chk("irq_clr", irq, 0);
        ex(OP_SEND_FUNC, 6'h01, 17'h0, 30'h1);
        chk("k1_strobe", s_fs, 0);
        ex(OP_SEND_FUNC, 6'h00, 17'h00004, 30'h0);
        chk("alarm_on", alarm, 1);
        ex(OP_SEND_FUNC, 6'h00, 17'h00008, 30'h0);
        chk("alarm_off", alarm, 0);
        ex(OP_OUTBUF_NOMON, 6'h07, 17'h0, 30'h0);
        chk("ef_start", s_ef, 1);
    endtask
    task automatic t_store();
        @(posedge clk);
        {int_chan, word, raise} <= {5'h03, 30'h2aaa5555, 1'h1};
        @(posedge clk);
        raise <= 1'h0;
        repeat (3) @(posedge clk);
        ex(OP_STORE_STATUS, 6'h00, 17'h1abcd, 30'h0);
        chk("k0_store", s_mw, 0);
        ex(OP_STORE_STATUS, 6'h03, 17'h1abcd, 30'h0);
        chk("st_addr", c_ma, 32'h1abcd);
        chk("st_data", c_md, 32'h2aaa5555);
        chk("ack", {c_ac, s_ack}, 32'h07);
        apb(1'h0, OFF_IRQ_STATUS, 32'h0);
        chk("ev_status", rd, 32'h0a);
    endtask
    task automatic t_jump();
        logic act;
        logic [31:0] v;
        logic [14:0] tg;
        for (int i = 0; i < 8; i++) begin
            act = i[0] ~^ i[2];
            v = {32{!act}};
            v[12] = act;
            // Every other channel shows the opposite state to catch a wrong index
            in_active <= i[2] ? ~v : v;
            out_active <= i[2] ? v : ~v;
            tg = (i[1:0] == 0) ? 15'h5a5a : (i[1:0] == 2) ? 15'h1234 : 15'h4321;
            ex(i[2] ? OP_JUMP_OUT : OP_JUMP_IN, {4'h0, i[1:0]}, 17'h05a5a, 30'h091a4321);
            chk("jump", s_j, act);
            if (act) chk("target", c_jt, tg);
        end
        chk("sel_held", chan_sel, 32'h0c);
    endtask
    task automatic t_term();
        {in_xfer_busy, mon_req} <= {2{32'h1000}};
        fork
            ex(OP_TERM_IN, 6'h00, 17'h1ffff, 30'h3fffffff);
            begin
                repeat (6) @(posedge clk);
                chk("term_busy", instr_busy, 1);
                in_xfer_busy <= 32'h0;
            end
        join
        chk("term_wait", ncyc > 4, 1);
        chk("term", {in_block[30:0], s_term}, 32'h2001);
        chk("mon_irq", mon_irq, 0);
        ex(OP_TERM_IN, 6'h04, 17'h0, 30'h0);
        chk("bad_term", s_term, 0);
        apb(1'h0, OFF_IN_BLOCK, 32'h0);
        chk("blk_read", rd, 32'h1000);
        // Reactivating the input buffer lifts the block and lets monitor through again
        in_activate <= 1'h1;
        @(posedge clk);
        in_activate <= 1'h0;
        repeat (2) @(posedge clk);
        chk("unblock", in_block, 32'h0);
        chk("mon_back", mon_irq, 1);
    endtask
    task automatic stop_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, instr_valid, in_activate, raise, reset_n} = '0;
        {paddr, pwdata, instr_opcode, instr_desig, instr_eaddr, instr_operand} = '0;
        {int_chan, word, in_active, out_active, in_xfer_busy, mon_req} = '0;
        {miscompares, n_compared, cyc} = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        t_send();
        t_store();
        t_jump();
        t_term();
        stop_test();
    end
endmodule
